// ==== rtl/dfcp_pkg.sv ====
// dfcp_pkg: constants, register defaults and types of the dual-format control port
// assumes: 8-bit registers behind a 4-bit index; shared by core and link modules
package dfcp_pkg;
    // register file shape
    localparam int REG_COUNT = 16;
    localparam int IDX_W = 4;
    localparam logic [IDX_W-1:0] IDX_ONE = 4'h1;
    localparam logic [IDX_W-1:0] ID_IDX = 4'h1;
    localparam logic [IDX_W-1:0] MISC_IDX = 4'h8;
    localparam int PDN_BIT = 7;
    localparam int PORT_ENABLE_BIT_BIT = 6;
    // pointer register: step enable in bit 7, index in 3:0, 6:4 read as zero
    localparam int AUTO_BIT = 7;
    localparam logic [7:0] PTR_MASK = 8'h8f;
    // slave addresses
    localparam logic [6:0] SPI_ADDR = 7'h4c;
    localparam logic [4:0] I2C_ADDR_HI = 5'h13;
    // bit and byte counting
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [3:0] I_BIT_LAST = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [1:0] BYTE_ADDR = 2'h0;
    localparam logic [1:0] BYTE_PTR = 2'h1;
    localparam logic [1:0] BYTE_DATA = 2'h2;
    // positions of the synchronised pins
    localparam int P_SCL = 0;
    localparam int P_SEL = 1;
    localparam int P_HI = 2;
    localparam int P_SDA = 3;
    // stand-alone power-up delay in system clock cycles
    localparam int STANDALONE_CYCLES = 2 ** 18;
    localparam logic [7:0] REG_DEFAULT [REG_COUNT] = '{
        8'h00, 8'h00, 8'h00, 8'h09, 8'hc0, 8'h00, 8'h00, 8'hb0,
        8'h80, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] REG_WMASK [REG_COUNT] = '{
        8'h00, 8'h00, 8'hff, 8'hff, 8'hfb, 8'hff, 8'hff, 8'hf5,
        8'hf8, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    typedef enum logic [1:0] {EV_PTR = 2'h0, EV_WR = 2'h1, EV_RD = 2'h2} dfcp_ev_e;
    typedef enum logic [2:0] {I2_IDLE = 3'h1, I2_RX = 3'h2, I2_TX = 3'h4} dfcp_i2c_e;
endpackage : dfcp_pkg

// ==== rtl/dfcp_link_if.sv ====
// dfcp_link_if: byte events from the serial-clock side and read data back
// assumes: event fields held stable while ev_toggle crosses into the system clock
`timescale 1ns/1ns
interface dfcp_link_if;
    logic ev_toggle;
    dfcp_pkg::dfcp_ev_e ev_kind;
    logic [7:0] ev_byte;
    logic [7:0] rd_word;
    logic spi_mode;
    modport link (output ev_toggle, ev_kind, ev_byte, input rd_word, spi_mode);
    modport core (input ev_toggle, ev_kind, ev_byte, output rd_word, spi_mode);
endinterface : dfcp_link_if

// ==== rtl/dfcp_spi_link.sv ====
// dfcp_spi_link: four-wire serial slave running on the control bit clock
// assumes: select high ends a frame and clears it; the bit clock only runs in frames
`timescale 1ns/1ns
module dfcp_spi_link (
    // link clock, frame and reset
    input wire logic sclk,
    input wire logic cs_pin,
    input wire logic resetn,
    // serial data
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    // towards the register core
    dfcp_link_if.link lk
);
    import dfcp_pkg::*;

    logic frame_rst;
    logic [7:0] rx_byte;
    logic [7:0] sh_q, sh_d;
    logic [2:0] cnt_q, cnt_d;
    logic [1:0] byte_no_q, byte_no_d;
    logic rd_q, rd_d, dead_q, dead_d;
    logic tgl_q, tgl_d;
    dfcp_ev_e kind_q, kind_d;
    logic [7:0] ev_q, ev_d;
    logic [1:0] mode_sync_q;
    logic [7:0] out_q, out_d;
    logic oe_q, oe_d;

    // the frame state dies with the select pin, so a stopped clock leaves nothing behind
    assign frame_rst = cs_pin | ~resetn;
    assign rx_byte = {sh_q[6:0], sdi}; // msb first

    // capture on rising edges, decode address, hand bytes over
    always_comb begin
        sh_d = rx_byte;
        cnt_d = cnt_q + 3'h1;
        byte_no_d = byte_no_q;
        rd_d = rd_q;
        dead_d = dead_q;
        tgl_d = tgl_q;
        kind_d = kind_q;
        ev_d = ev_q;
        if (cnt_q == BIT_LAST && !dead_q) begin
            if (byte_no_q == BYTE_ADDR) begin
                dead_d = (rx_byte[7:1] != SPI_ADDR);
                rd_d = rx_byte[0];
            end else if (!rd_q) begin
                kind_d = (byte_no_q == BYTE_PTR) ? EV_PTR : EV_WR;
                ev_d = rx_byte;
                tgl_d = ~tgl_q;
            end
            if (byte_no_q != BYTE_DATA) begin
                byte_no_d = byte_no_q + 2'h1;
            end
        end
        // step the pointer once a read byte is loaded, well before the next load
        if (cnt_q == BIT_FIRST && rd_q && !dead_q) begin
            kind_d = EV_RD;
            tgl_d = ~tgl_q;
        end
    end

    always_ff @(posedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            sh_q <= 8'h00;
            cnt_q <= 3'h0;
            byte_no_q <= BYTE_ADDR;
            rd_q <= 1'b0;
            dead_q <= 1'b0;
        end else begin
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            byte_no_q <= byte_no_d;
            rd_q <= rd_d;
            dead_q <= dead_d;
        end
    end

    // event word survives frame ends; it is only qualified by the toggle
    always_ff @(posedge sclk or negedge resetn) begin
        if (!resetn) begin
            tgl_q <= 1'b0;
            kind_q <= EV_PTR;
            ev_q <= 8'h00;
            mode_sync_q <= 2'h0;
        end else begin
            tgl_q <= tgl_d;
            kind_q <= kind_d;
            ev_q <= ev_d;
            mode_sync_q <= {mode_sync_q[0], lk.spi_mode};
        end
    end

    // read data changes on falling edges so the host samples on rising
    always_comb begin
        out_d = out_q << 1;
        oe_d = 1'b0;
        if (rd_q && !dead_q) begin
            if (cnt_q == BIT_FIRST) begin
                out_d = lk.rd_word;
            end
            oe_d = mode_sync_q[1]; // never drive the shared pin in two-wire mode
        end
    end

    always_ff @(negedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            out_q <= 8'h00;
            oe_q <= 1'b0;
        end else begin
            out_q <= out_d;
            oe_q <= oe_d;
        end
    end

    assign sdo = out_q[7];
    assign sdo_oe = oe_q;
    assign lk.ev_toggle = tgl_q;
    assign lk.ev_kind = kind_q;
    assign lk.ev_byte = ev_q;

    AST_SPI_OE_READ: assert property (@(negedge sclk) disable iff (frame_rst)
        oe_q |-> (rd_q && !dead_q))
        else $error("serial out driven outside a read");
    AST_SPI_PTR_EVENT: assert property (@(posedge sclk) disable iff (frame_rst)
        (cnt_q == BIT_LAST && byte_no_q == BYTE_PTR && !rd_q && !dead_q)
        |=> (kind_q == EV_PTR && ev_q == $past(rx_byte) && tgl_q != $past(tgl_q)))
        else $error("pointer byte not handed over");
endmodule : dfcp_spi_link

// ==== rtl/dfcp_top.sv ====
// dfcp_top: dual-format serial control port with its configuration registers
// assumes: pins arrive asynchronously; CLK is the system clock; the four-wire
// half runs on the control bit clock inside dfcp_spi_link
//
// Operation
// - register access independent of audio clocks
// - pointer: step bit 7, index 3:0, reset zero
// - step off keeps index across data bytes
// - step on advances index after each byte
// - port enabled by writing enable bit serially
// - enable stops stand-alone start, restores defaults
// - slave only; two-wire default, select fall picks four-wire
// - two-wire address 10011 plus two pins
// - receiver acknowledges every byte
// - write: address, pointer, data bytes, stop
// - read: address then data from pointer
// - four-wire inputs captured on rising bit clock
// - serial out released except during read
// - four-wire write: 1001100, low, pointer, data
// - four-wire read: 1001100, high, data out
// - enable and power-down live in register 8
`timescale 1ns/1ns
module dfcp_top #(
    parameter int STANDALONE_CYCLES = dfcp_pkg::STANDALONE_CYCLES,
    parameter logic [7:0] CHIP_ID = 8'h5a // arbitrary identification value
) (
    // system clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // shared control pins
    input wire logic CTRL_BIT_CLOCK,
    input wire logic ADDR_LO_OR_SELECT_PIN,
    input wire logic ADDR_HI_PIN,
    // two-wire data line, open drain
    input wire logic CTRL_SERIAL_IN_I,
    output logic CTRL_SERIAL_IN_O,
    output logic CTRL_SERIAL_IN_OE,
    // four-wire serial out, shares the pad of ADDR_HI_PIN
    output logic CTRL_SERIAL_OUT_O,
    output logic CTRL_SERIAL_OUT_OE,
    // configuration towards the converter
    output logic [dfcp_pkg::REG_COUNT*8-1:0] CFG_REGS,
    output logic PORT_ENABLED,
    output logic POWER_DOWN,
    output logic STANDALONE_RUN,
    output logic SPI_MODE
);
    import dfcp_pkg::*;
    localparam int SA_W = $clog2(STANDALONE_CYCLES) + 1;

    dfcp_link_if lk ();

    logic [3:0] pin_raw, sync1_q, sync2_q, prev_q;
    logic scl_s, sda_s, scl_rise, scl_fall, i_start, i_stop, sel_fall;
    logic [2:0] tg_q;
    logic spi_ev, i2c_ev, ev_v;
    dfcp_ev_e i2c_k, ev_k;
    logic [7:0] i2c_b, ev_b, i_rx;
    logic [7:0] regs_q [REG_COUNT];
    logic [7:0] regs_d [REG_COUNT];
    logic [7:0] ptr_q, ptr_d;
    logic [IDX_W-1:0] idx;
    logic auto_step, port_enable_bit_set;
    dfcp_i2c_e st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] ish_q, ish_d;
    logic [1:0] ibn_q, ibn_d;
    logic ird_q, ird_d, ack_q, ack_d, sda_oe_q, sda_oe_d;
    logic spi_mode_q, spi_mode_d, sa_run_q, sa_run_d;
    logic [SA_W-1:0] sa_cnt_q, sa_cnt_d;
    logic [7:0] rd_word_q, rd_word_d;

    // register read decode, shared by both serial formats
    function automatic logic [7:0] reg_read(input logic [IDX_W-1:0] i,
                                            input logic [7:0] v);
        reg_read = (i == ID_IDX) ? CHIP_ID : v;
    endfunction : reg_read

    // every pin passes two flops; a third copy only feeds edge detection
    assign pin_raw = {CTRL_SERIAL_IN_I, ADDR_HI_PIN, ADDR_LO_OR_SELECT_PIN, CTRL_BIT_CLOCK};
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            prev_q <= 4'h0;
            tg_q <= 3'h0;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
            tg_q <= {tg_q[1:0], lk.ev_toggle};
        end
    end

    // pin events; start and stop are data edges while the clock stays high
    assign scl_s = sync2_q[P_SCL];
    assign sda_s = sync2_q[P_SDA];
    assign scl_rise = scl_s & ~prev_q[P_SCL];
    assign scl_fall = ~scl_s & prev_q[P_SCL];
    assign i_start = scl_s & prev_q[P_SCL] & prev_q[P_SDA] & ~sda_s;
    assign i_stop = scl_s & prev_q[P_SCL] & ~prev_q[P_SDA] & sda_s;
    assign sel_fall = prev_q[P_SEL] & ~sync2_q[P_SEL];
    assign i_rx = {ish_q[6:0], sda_s}; // msb first

    // four-wire half on its own clock; select doubles as its frame reset
    dfcp_spi_link u_link (
        .sclk(CTRL_BIT_CLOCK),
        .cs_pin(ADDR_LO_OR_SELECT_PIN),
        .resetn(RESETN),
        .sdi(CTRL_SERIAL_IN_I),
        .sdo(CTRL_SERIAL_OUT_O),
        .sdo_oe(CTRL_SERIAL_OUT_OE),
        .lk(lk.link)
    );

    // two-wire engine: bits on rising clock, drive only after falling clock
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        ish_d = ish_q;
        ibn_d = ibn_q;
        ird_d = ird_q;
        ack_d = ack_q;
        sda_oe_d = sda_oe_q;
        i2c_ev = 1'b0;
        i2c_k = EV_WR;
        i2c_b = i_rx;
        if (spi_mode_q || i_stop) begin
            st_d = I2_IDLE;
            sda_oe_d = 1'b0;
            ack_d = 1'b0;
        end else if (i_start) begin
            st_d = I2_RX;
            cnt_d = 4'h0;
            ibn_d = BYTE_ADDR;
            ack_d = 1'b0;
            sda_oe_d = 1'b0;
        end else if (scl_fall && st_q != I2_IDLE) begin
            // ack slot pulls low; read bits pull low for a zero
            sda_oe_d = (cnt_q == ACK_SLOT) ? ack_q : (st_q == I2_TX && !ish_q[7]);
        end else if (scl_rise && st_q != I2_IDLE) begin
            if (cnt_q != ACK_SLOT) begin
                ish_d = i_rx;
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == I_BIT_LAST && st_q == I2_RX) begin
                    ack_d = 1'b1;
                    if (ibn_q == BYTE_ADDR) begin
                        ird_d = i_rx[0];
                        if (i_rx[7:1] != {I2C_ADDR_HI, sync2_q[P_HI], sync2_q[P_SEL]}) begin
                            st_d = I2_IDLE; // not ours: stay silent until next start
                            ack_d = 1'b0;
                        end
                    end else begin
                        i2c_ev = 1'b1; // second byte is the pointer, then data
                        i2c_k = (ibn_q == BYTE_PTR) ? EV_PTR : EV_WR;
                    end
                    if (ibn_q != BYTE_DATA) begin
                        ibn_d = ibn_q + 2'h1;
                    end
                end
            end else begin
                cnt_d = 4'h0;
                ack_d = 1'b0;
                if ((st_q == I2_RX && ird_q) || (st_q == I2_TX && !sda_s)) begin
                    st_d = I2_TX; // host ack or read address: load next byte
                    ish_d = reg_read(idx, regs_q[idx]);
                    i2c_ev = 1'b1;
                    i2c_k = EV_RD;
                end else if (st_q == I2_TX) begin
                    st_d = I2_IDLE; // host did not ack: release and wait for stop
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_q <= I2_IDLE;
            cnt_q <= 4'h0;
            ish_q <= 8'h00;
            ibn_q <= BYTE_ADDR;
            ird_q <= 1'b0;
            ack_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            ish_q <= ish_d;
            ibn_q <= ibn_d;
            ird_q <= ird_d;
            ack_q <= ack_d;
            sda_oe_q <= sda_oe_d;
        end
    end

    // merge byte events; four-wire events count only once that format is chosen
    assign spi_ev = (tg_q[2] ^ tg_q[1]) & spi_mode_q;
    always_comb begin
        ev_v = spi_ev | i2c_ev;
        ev_k = spi_ev ? lk.ev_kind : i2c_k;
        ev_b = spi_ev ? lk.ev_byte : i2c_b;
    end

    assign idx = ptr_q[IDX_W-1:0];
    assign auto_step = ptr_q[AUTO_BIT];
    assign port_enable_bit_set = (idx == MISC_IDX) && ev_b[PORT_ENABLE_BIT_BIT] && !regs_q[MISC_IDX][PORT_ENABLE_BIT_BIT];

    // register file and pointer; reserved bits keep their defaults
    always_comb begin
        regs_d = regs_q;
        ptr_d = ptr_q;
        if (ev_v) begin
            case (ev_k)
                EV_PTR: ptr_d = ev_b & PTR_MASK;
                EV_WR: begin
                    regs_d[idx] = (regs_q[idx] & ~REG_WMASK[idx]) | (ev_b & REG_WMASK[idx]);
                    if (auto_step) begin
                        ptr_d[IDX_W-1:0] = idx + IDX_ONE;
                    end
                    if (port_enable_bit_set) begin
                        regs_d = REG_DEFAULT;
                        regs_d[MISC_IDX][PORT_ENABLE_BIT_BIT] = 1'b1;
                        ptr_d = 8'h00;
                    end
                end
                EV_RD: begin
                    if (auto_step) begin
                        ptr_d[IDX_W-1:0] = idx + IDX_ONE;
                    end
                end
                default: ptr_d = ptr_q; // pointer held for any other event kind
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            regs_q <= REG_DEFAULT;
            ptr_q <= 8'h00;
        end else begin
            regs_q <= regs_d;
            ptr_q <= ptr_d;
        end
    end

    // format pick, stand-alone delay and read word for the link side
    always_comb begin
        spi_mode_d = spi_mode_q | sel_fall; // sticky until power cycles
        sa_cnt_d = sa_cnt_q;
        sa_run_d = sa_run_q;
        // a late enable halts the count and also clears a started run
        if (!regs_q[MISC_IDX][PORT_ENABLE_BIT_BIT] && !sa_run_q) begin
            sa_cnt_d = sa_cnt_q + SA_W'(1);
            sa_run_d = (sa_cnt_q == SA_W'(STANDALONE_CYCLES - 1));
        end
        if (regs_q[MISC_IDX][PORT_ENABLE_BIT_BIT]) begin
            sa_run_d = 1'b0; // enable halts the stand-alone start
        end
        rd_word_d = reg_read(idx, regs_q[idx]);
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            spi_mode_q <= 1'b0;
            sa_cnt_q <= '0;
            sa_run_q <= 1'b0;
            rd_word_q <= 8'h00;
        end else begin
            spi_mode_q <= spi_mode_d;
            sa_cnt_q <= sa_cnt_d;
            sa_run_q <= sa_run_d;
            rd_word_q <= rd_word_d;
        end
    end

    // the open-drain line only ever pulls low
    assign CTRL_SERIAL_IN_O = 1'b0;
    assign CTRL_SERIAL_IN_OE = sda_oe_q;
    assign lk.rd_word = rd_word_q;
    assign lk.spi_mode = spi_mode_q;
    assign PORT_ENABLED = regs_q[MISC_IDX][PORT_ENABLE_BIT_BIT];
    assign POWER_DOWN = regs_q[MISC_IDX][PDN_BIT];
    assign STANDALONE_RUN = sa_run_q;
    assign SPI_MODE = spi_mode_q;
    for (genvar g = 0; g < REG_COUNT; g++) begin : g_cfg
        assign CFG_REGS[g*8 +: 8] = regs_q[g];
    end

    sequence s_port_enable_bit_write;
        ev_v && ev_k == EV_WR && port_enable_bit_set;
    endsequence

    sequence s_addr_ok;
        scl_rise && st_q == I2_RX && ibn_q == BYTE_ADDR && cnt_q == I_BIT_LAST
            && i_rx[7:1] == {I2C_ADDR_HI, sync2_q[P_HI], sync2_q[P_SEL]};
    endsequence

    AST_FMT_SEL: assert property (@(posedge CLK) disable iff (!RESETN)
        sel_fall |=> spi_mode_q [*8])
        else $error("select fall did not pick four-wire format");
    AST_TWO_WIRE_QUIET: assert property (@(posedge CLK) disable iff (!RESETN)
        spi_mode_q |=> !CTRL_SERIAL_IN_OE)
        else $error("data line driven in four-wire format");
    AST_PTR_HOLD: assert property (@(posedge CLK) disable iff (!RESETN)
        (ev_v && ev_k != EV_PTR && !auto_step && !port_enable_bit_set) |=> ptr_q == $past(ptr_q))
        else $error("index moved with stepping off");
    AST_PTR_STEP: assert property (@(posedge CLK) disable iff (!RESETN)
        (ev_v && ev_k != EV_PTR && auto_step && !(ev_k == EV_WR && port_enable_bit_set))
        |=> idx == $past(idx) + IDX_ONE)
        else $error("index did not advance");
    AST_PTR_RESV: assert property (@(posedge CLK) disable iff (!RESETN)
        (ev_v && ev_k == EV_PTR) |=> (ptr_q & ~PTR_MASK) == 8'h00 && ptr_q == ($past(ev_b) & PTR_MASK))
        else $error("pointer load wrong");
    AST_PORT_ENABLE_BIT_INIT: assert property (@(posedge CLK) disable iff (!RESETN)
        s_port_enable_bit_write |=> (PORT_ENABLED && POWER_DOWN && ptr_q == 8'h00) ##1 !STANDALONE_RUN)
        else $error("enable did not restore defaults");
    AST_ADDR_ACK: assert property (@(posedge CLK) disable iff (!RESETN)
        s_addr_ok ##[1:20] (!i_start && !i_stop && !spi_mode_q && scl_fall
            && st_q == I2_RX && cnt_q == ACK_SLOT)
        |=> CTRL_SERIAL_IN_OE)
        else $error("own address not acknowledged");
endmodule : dfcp_top

// ==== test/dfcp_host_model.sv ====
// dfcp_host_model: host master for both control port formats
// assumes: sda is the resolved open-drain line; bit clock runs only in frames
`timescale 1ns/1ns
module dfcp_host_model (
    // two-wire pacing clock
    input wire logic clk,
    // lines seen by the host
    input wire logic sda,
    input wire logic sdo,
    // host pins
    output logic scl,
    output logic sel_n,
    output logic dat
);
    // lines stay static while idle
    initial begin
        scl = 1'b1;
        sel_n = 1'b1;
        dat = 1'b1;
    end
    // one bit: data moves while scl low, sampled mid-high
    task automatic i2c_bit(input logic b, output logic r);
        dat <= b;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (2) @(posedge clk);
        r = sda;
        repeat (2) @(posedge clk);
        scl <= 1'b0;
        @(posedge clk);
    endtask : i2c_bit
    // byte msb first, then the ack slot
    task automatic i2c_byte(input logic [7:0] d, input logic hack, output logic [7:0] q,
                            output logic ack);
        for (int i = 7; i >= 0; i--) i2c_bit(d[i], q[i]);
        i2c_bit(hack, ack);
    endtask : i2c_byte
    // start: data falls while scl high
    task automatic i2c_start();
        dat <= 1'b1;
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        dat <= 1'b0;
        repeat (4) @(posedge clk);
        scl <= 1'b0;
        @(posedge clk);
    endtask : i2c_start
    // stop: data rises while scl high
    task automatic i2c_stop();
        dat <= 1'b0;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        dat <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : i2c_stop
    // 30 ns bit clock, data set after each fall, read data taken at rise
    task automatic spi_frame(input logic [7:0] b [$], output logic [7:0] q [$]);
        logic [7:0] r;
        q = {};
        #7 scl = 1'b0;
        #10 sel_n = 1'b0;
        foreach (b[k]) begin
            for (int i = 7; i >= 0; i--) begin
                dat = b[k][i];
                #15 scl = 1'b1;
                r[i] = sdo;
                #15 scl = 1'b0;
            end
            q.push_back(r);
        end
        #15 sel_n = 1'b1;
    endtask : spi_frame
endmodule : dfcp_host_model

// ==== test/dfcp_top_tb_top.sv ====
// dfcp_top_tb_top: self-checking bench for the dual-format control port
// assumes: open-drain data line pulled up; address pins set for two-wire 1001101
`timescale 1ns/1ns
module dfcp_top_tb_top;
    import dfcp_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic scl, sel_n, dat, sda, sdo, in_o, in_oe, out_o, out_oe, en, power_down_bit, sa, spi;
    logic [REG_COUNT*8-1:0] regs;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    // pulled-up line; a released serial out shows the inverse of its last bit
    assign sda = in_oe ? in_o : dat;
    assign sdo = out_oe ? out_o : ~out_o;
    dfcp_host_model u_host (.clk(clk), .sda(sda), .sdo(sdo), .scl(scl), .sel_n(sel_n),
        .dat(dat));
    dfcp_top #(.STANDALONE_CYCLES(64)) u_dut (.CLK(clk), .RESETN(resetn),
        .CTRL_BIT_CLOCK(scl), .ADDR_LO_OR_SELECT_PIN(sel_n), .ADDR_HI_PIN(1'b0),
        .CTRL_SERIAL_IN_I(sda), .CTRL_SERIAL_IN_O(in_o), .CTRL_SERIAL_IN_OE(in_oe),
        .CTRL_SERIAL_OUT_O(out_o), .CTRL_SERIAL_OUT_OE(out_oe), .CFG_REGS(regs),
        .PORT_ENABLED(en), .POWER_DOWN(power_down_bit), .STANDALONE_RUN(sa), .SPI_MODE(spi));
    // free-running system clock
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic print_verdict();
        if (fails == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    function automatic logic [7:0] rg(input int g);
        return regs[g*8+:8];
    endfunction : rg
    // whole two-wire write, every byte's ack slot compared
    task automatic i2c_wr(input logic [7:0] b [$], input logic [7:0] ack_e);
        logic [7:0] q;
        logic a;
        u_host.i2c_start();
        foreach (b[k]) begin
            u_host.i2c_byte(b[k], 1'b1, q, a);
            chk("ack", ack_e, {7'h0, a});
        end
        u_host.i2c_stop();
    endtask : i2c_wr
    task automatic t_reset();
        for (int g = 0; g < REG_COUNT; g++) begin
            if (g != 1) chk("default", REG_DEFAULT[g], rg(g));
        end
        chk("reg8", 8'h80, rg(8));
        chk("flags", 8'h08, {4'h0, power_down_bit, en, spi, in_oe | out_oe});
    endtask : t_reset
    task automatic t_enable();
        repeat (70) @(posedge clk);
        chk("standalone", 8'h01, {7'h0, sa});
        i2c_wr('{8'h9a, 8'h05, 8'h33}, 8'h00);
        chk("reg5", 8'h33, rg(5));
        i2c_wr('{8'h9a, 8'h08, 8'h40}, 8'h00);
        repeat (4) @(posedge clk);
        chk("enabled", 8'h05, {5'h0, en, sa, power_down_bit});
        chk("reg5 restored", 8'h00, rg(5));
    endtask : t_enable
    task automatic t_step();
        i2c_wr('{8'h9a, 8'h87, 8'h11, 8'h40}, 8'h00);
        chk("reg7", 8'h11, rg(7));
        chk("reg8", 8'h40, rg(8));
        chk("pdn", 8'h00, {7'h0, power_down_bit});
    endtask : t_step
    task automatic t_hold();
        i2c_wr('{8'h9a, 8'h75, 8'h44, 8'h55}, 8'h00);
        chk("reg5", 8'h55, rg(5));
        chk("reg6", 8'h00, rg(6));
    endtask : t_hold
    // read from the pointer left by a pointer-only write, last byte refused by host
    task automatic t_read();
        logic [7:0] q;
        logic a;
        i2c_wr('{8'h9a, 8'h85}, 8'h00);
        u_host.i2c_start();
        u_host.i2c_byte(8'h9b, 1'b1, q, a);
        chk("read ack", 8'h00, {7'h0, a});
        u_host.i2c_byte(8'hff, 1'b0, q, a);
        chk("rd0", 8'h55, q);
        u_host.i2c_byte(8'hff, 1'b0, q, a);
        chk("rd1", 8'h00, q);
        u_host.i2c_byte(8'hff, 1'b1, q, a);
        chk("rd2", 8'h11, q);
        u_host.i2c_stop();
        i2c_wr('{8'h92}, 8'h01);
    endtask : t_read
    task automatic t_spi();
        logic [7:0] q [$];
        u_host.spi_frame('{8'h98, 8'h87, 8'ha5}, q);
        repeat (8) @(posedge clk);
        chk("spi mode", 8'h01, {7'h0, spi});
        chk("reg7", 8'ha5, rg(7));
        u_host.spi_frame('{8'h99, 8'hff, 8'hff}, q);
        chk("spi rd0", 8'h40, q[1]);
        chk("spi rd1", 8'h08, q[2]);
        #20;
        chk("out oe", 8'h00, {7'h0, out_oe});
        @(posedge clk);
        i2c_wr('{8'h9a}, 8'h01);
    endtask : t_spi
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_enable();
        t_step();
        t_hold();
        t_read();
        t_spi();
        print_verdict();
    end
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            print_verdict();
        end
    end
endmodule : dfcp_top_tb_top
